// [verilog/exec_pkg.sv]
// Operation
// - Literal add stores accumulator plus literal in the accumulator and updates all flags.
// - Literal AND masks the accumulator with the literal and updates only the zero flag.
// - Register AND masks the accumulator with the file cell and updates only zero.
// - Destination bit clear writes the accumulator, and set writes the file cell.
// - Each opcode here is one word and ends in one instruction cycle with no idle cycle.
// - Every instruction cycle is made of four consecutive oscillator periods.
// - A register opcode reading the port takes the pin levels, not the output latch.
// - A write to the timer count register clears the prescaler while it serves the timer.
package exec_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int WORD_W = 14;
  localparam int MEM_DEPTH = 128;

  // Field positions inside the 14-bit program word.
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int NIBBLE_BIT = 4;

  // Opcode values of the upper six bits.
  localparam logic [5:0] OPC_ADD_IMM = 6'h3E;
  localparam logic [5:0] OPC_ADD_IMM_MASK = 6'h3E;
  localparam logic [5:0] OPC_AND_IMM = 6'h39;
  localparam logic [5:0] OPC_AND_REG = 6'h05;
  localparam logic [5:0] OPC_ADD_REG = 6'h07;

  // File register addresses with side effects.
  localparam logic [6:0] ADDR_TIMER = 7'h01;
  localparam logic [6:0] ADDR_PORT = 7'h06;

  // Reset values.
  localparam logic [7:0] ACCUM_RST = 8'h00;
  localparam logic [13:0] WORD_RST = 14'h0000;

  localparam int PERIODS_PER_CYCLE = 4;

  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } phase_e;

  typedef enum logic [4:0] {
    OP_NONE = 5'b00001,
    OP_ADD_IMM = 5'b00010,
    OP_AND_IMM = 5'b00100,
    OP_AND_REG = 5'b01000,
    OP_ADD_REG = 5'b10000
  } op_e;

endpackage

// [verilog/file_mem_if.sv]
`timescale 1ns/1ns
interface file_mem_if;
  logic [6:0] addr;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport core (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface

// [verilog/file_mem.sv]
`timescale 1ns/1ns
module file_mem
  import exec_pkg::*;
(
  input wire logic clock,
  file_mem_if.mem bus
);

  logic [DATA_W-1:0] cells [MEM_DEPTH];

  // No reset on the array, so it maps onto plain storage.
  always_ff @(posedge clock) begin
    if (bus.we) begin
      cells[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge clock) begin
    bus.rdata <= cells[bus.addr];
  end

endmodule

// [verilog/accum_add_and_exec_unit.sv]
`timescale 1ns/1ns
module accum_add_and_exec_unit
  import exec_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic [7:0] port_pins,
  input wire logic prescaler_to_timer,
  output logic instr_ready,
  output logic exec_done,
  output logic [7:0] accum,
  output logic carry_flag,
  output logic nibble_overflow_bit,
  output logic zero_flag,
  output logic prescaler_clear
);

  ////////////////////////////////////////////////////////////////////////////
  // Opcode decode, used for the latched word and the operand path.

  function automatic op_e decode(input logic [13:0] word);
    logic [5:0] opc;
    opc = word[OPC_HI:OPC_LO];
    if ((opc & OPC_ADD_IMM_MASK) == OPC_ADD_IMM) begin
      decode = OP_ADD_IMM;
    end else if (opc == OPC_AND_IMM) begin
      decode = OP_AND_IMM;
    end else if (opc == OPC_AND_REG) begin
      decode = OP_AND_REG;
    end else if (opc == OPC_ADD_REG) begin
      decode = OP_ADD_REG;
    end else begin
      decode = OP_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Four-period instruction cycle.

  phase_e phase;
  phase_e next_phase;

  // Four period sequencer.
  // The ring free-runs, so the cycle stays four periods long whether or not a word is live.
  always_comb begin
    case (phase)
      PH_Q1: next_phase = PH_Q2;
      PH_Q2: next_phase = PH_Q3;
      PH_Q3: next_phase = PH_Q4;
      PH_Q4: next_phase = PH_Q1;
      default: next_phase = PH_Q1;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase <= PH_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction latch.

  logic [13:0] ir;
  logic ir_live;

  // A word is only taken in the first period, so a new one can arrive every cycle.
  assign instr_ready = (phase == PH_Q1);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ir <= WORD_RST;
      ir_live <= 1'b0;
    end else if (phase == PH_Q1) begin
      ir <= instr_word;
      ir_live <= instr_valid;
    end
  end

  op_e op;
  assign op = ir_live ? decode(ir) : OP_NONE;

  logic [6:0] faddr;
  logic dest_file;
  logic [7:0] literal;
  assign faddr = ir[ADDR_W-1:0];
  assign dest_file = ir[DEST_BIT];
  assign literal = ir[DATA_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // File register access.

  file_mem_if fbus ();

  file_mem u_file_mem (
    .clock(clock),
    .bus(fbus)
  );

  // Operand captured in the third period, after the registered read settles.
  logic [7:0] operand;

  // Port reads take the pins.
  // The file read is registered, so the cell of a newly latched address is only valid
  // from the third period; an earlier sample would see the previous word's cell.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      operand <= ACCUM_RST;
    end else if (phase == PH_Q3) begin
      operand <= (faddr == ADDR_PORT) ? port_pins : fbus.rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic and logic.

  logic [7:0] src_b;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] result;
  logic is_add;
  logic is_reg;
  logic known;
  logic to_file;
  logic to_accum;
  logic [7:0] masked;

  assign known = (op != OP_NONE);
  assign is_add = (op == OP_ADD_IMM) || (op == OP_ADD_REG);
  assign is_reg = (op == OP_AND_REG) || (op == OP_ADD_REG);
  assign src_b = is_reg ? operand : literal;
  assign sum = {1'b0, accum} + {1'b0, src_b};
  assign low_sum = {1'b0, accum[3:0]} + {1'b0, src_b[3:0]};

  // Bitwise mask, one slice per data bit.
  for (genvar i = 0; i < DATA_W; i++) begin : g_mask
    assign masked[i] = accum[i] & src_b[i];
  end

  assign result = is_add ? sum[7:0] : masked;

  // Destination steering.
  // A register opcode with the file destination leaves the accumulator alone.
  assign to_file = is_reg && dest_file;
  assign to_accum = known && !to_file;

  logic timer_write;
  // Only a file write counts; merely reading the timer leaves the prescaler alone.
  assign timer_write = to_file && (faddr == ADDR_TIMER);

  // Results are committed at the last period edge, ending the cycle on time.
  logic commit;
  assign commit = (phase == PH_Q4);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      accum <= ACCUM_RST;
    end else if (commit && to_accum) begin
      accum <= result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags and side effects.

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      carry_flag <= 1'b0;
    end else if (commit && is_add) begin
      carry_flag <= sum[DATA_W];
    end
  end

  // Nibble carry on sums.
  // Masks keep both carries, so a mask between two sums cannot disturb a carry chain.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      nibble_overflow_bit <= 1'b0;
    end else if (commit && is_add) begin
      nibble_overflow_bit <= low_sum[NIBBLE_BIT];
    end
  end

  // Zero flag for every opcode here.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      zero_flag <= 1'b0;
    end else if (commit && known) begin
      zero_flag <= (result == 8'h00);
    end
  end

  assign fbus.addr = faddr;
  assign fbus.we = commit && to_file;
  assign fbus.wdata = result;

  // Prescaler clear on timer write.
  // A single pulse per write is enough for the prescaler to drop its count.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prescaler_clear <= 1'b0;
    end else begin
      prescaler_clear <= commit && timer_write && prescaler_to_timer;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      exec_done <= 1'b0;
    end else begin
      exec_done <= commit && known;
    end
  end

endmodule

// [dv/accum_exec_chk.sv]
`timescale 1ns/1ns
module accum_exec_chk
  import exec_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic [7:0] port_pins,
  input wire logic prescaler_to_timer,
  input wire logic instr_ready,
  input wire logic exec_done,
  input wire logic [7:0] accum,
  input wire logic carry_flag,
  input wire logic nibble_overflow_bit,
  input wire logic zero_flag,
  input wire logic prescaler_clear
);
  logic take;
  logic [5:0] opc;
  assign take = instr_ready && instr_valid;
  assign opc = instr_word[13:8];
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  a_ready_period: assert property (instr_ready |=> !instr_ready [*3] ##1 instr_ready)
    else $error("ready period wrong");
  a_done_latency: assert property (take && opc == OPC_AND_IMM |-> ##4 exec_done)
    else $error("done not after four clocks");
  a_and_imm: assert property (take && opc == OPC_AND_IMM |-> ##4
    accum == ($past(accum, 4) & $past(instr_word[7:0], 4)) && $stable(carry_flag))
    else $error("mask immediate wrong");
  a_add_imm: assert property (take && opc[5:1] == 5'h1F |-> ##4
    {carry_flag, accum} == {1'b0, $past(accum, 4)} + {1'b0, $past(instr_word[7:0], 4)})
    else $error("sum immediate wrong");
  a_reg_keeps_acc: assert property (take && opc[5:4] == 2'b00 && instr_word[7] |-> ##4
    accum == $past(accum, 4)) else $error("file destination touched accumulator");
  a_port_source: assert property (take && opc == OPC_AND_REG &&
    instr_word[7:0] == {1'b0, ADDR_PORT} |-> ##4 accum == ($past(accum, 4) & $past(port_pins, 2)))
    else $error("port read not from pins");
  a_and_reg_zero: assert property (take && opc == OPC_AND_REG && !instr_word[7] |-> ##4
    zero_flag == (accum == 8'h00)) else $error("mask register zero wrong");
  a_add_reg_zero: assert property (take && opc == OPC_ADD_REG && !instr_word[7] |-> ##4
    zero_flag == (accum == 8'h00)) else $error("sum register zero wrong");
  a_prescale_cause: assert property (prescaler_clear |->
    $past(instr_word[7:0], 4) == {1'b1, ADDR_TIMER} && exec_done)
    else $error("prescaler clear without timer write");
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ns
bind accum_add_and_exec_unit accum_exec_chk chk (.clock(clock), .nrst(nrst),
  .instr_valid(instr_valid), .instr_word(instr_word), .port_pins(port_pins),
  .prescaler_to_timer(prescaler_to_timer), .instr_ready(instr_ready), .exec_done(exec_done),
  .accum(accum), .carry_flag(carry_flag), .nibble_overflow_bit(nibble_overflow_bit),
  .zero_flag(zero_flag), .prescaler_clear(prescaler_clear));
module testbench
  import exec_pkg::*;
;
  logic clock = 0, nrst = 0, instr_valid = 0, prescaler_to_timer = 0;
  logic [13:0] instr_word = WORD_RST;
  logic [7:0] port_pins = 8'h00;
  logic instr_ready, exec_done, carry_flag, nibble_overflow_bit, zero_flag, prescaler_clear;
  logic [7:0] accum, w = ACCUM_RST, mem [128];
  logic c = 0, nib = 0, z = 0, ed = 0, pc = 0;
  int n_fail = 0, n_tests = 0, cyc = 0;
  accum_add_and_exec_unit dut (.clock, .nrst, .instr_valid, .instr_word, .port_pins,
    .prescaler_to_timer, .instr_ready, .exec_done, .accum, .carry_flag,
    .nibble_overflow_bit, .zero_flag, .prescaler_clear);
  initial forever #25 clock = ~clock;
  // A hang ends the run with a counted failure instead of spinning forever.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 1000) begin
      n_fail++;
      report_and_stop;
    end
  end
  ////////////////////////////////////////
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic judge;
    check(accum, w);
    check(carry_flag, c);
    check(nibble_overflow_bit, nib);
    check(zero_flag, z);
    check(exec_done, ed);
    check(prescaler_clear, pc);
  endtask
  // Results of the previous word are judged while the next word waits for its take edge.
  task automatic op(input logic [5:0] o, input logic [7:0] lo);
    logic [7:0] v;
    logic [8:0] s;
    logic imm, add, ok, d;
    instr_valid <= 1'b1;
    instr_word <= {o, lo};
    @(negedge clock);
    judge;
    imm = o[5];
    d = lo[7] & ~imm;
    add = o == OPC_ADD_REG || o[5:1] == 5'h1F;
    ok = add || o == OPC_AND_IMM || o == OPC_AND_REG;
    v = imm ? lo : (lo[6:0] == ADDR_PORT ? port_pins : mem[lo[6:0]]);
    s = add ? w + v : {c, w & v};
    ed = ok;
    pc = ok && d && lo[6:0] == ADDR_TIMER && prescaler_to_timer;
    if (ok) begin
      if (add) begin
        c = s[8];
        nib = (w[3:0] + v[3:0]) > 15;
      end
      z = s[7:0] == 8'h00;
      if (d) mem[lo[6:0]] = s[7:0];
      else w = s[7:0];
    end
    @(posedge clock);
    instr_valid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] val);
    op(OPC_AND_IMM, 8'h00);
    op(OPC_AND_REG, {1'b1, a});
    op(OPC_ADD_IMM, val);
    op(OPC_ADD_REG, {1'b1, a});
  endtask
  task automatic t_imm;
    op(OPC_AND_IMM, 8'h00);
    op(OPC_ADD_IMM, 8'hFF);
    op(6'h3F, 8'h01);
    op(OPC_ADD_IMM, 8'h10);
    op(6'h3F, 8'h15);
    op(OPC_AND_IMM, 8'h5F);
  endtask
  task automatic t_reg;
    wr(7'h20, 8'hC2);
    op(OPC_AND_IMM, 8'h00);
    op(OPC_ADD_IMM, 8'h17);
    op(OPC_ADD_REG, 8'h20);
    op(OPC_AND_REG, 8'hA0);
    op(OPC_ADD_REG, 8'hA0);
    op(OPC_AND_IMM, 8'h00);
    op(OPC_ADD_REG, 8'h20);
    op(OPC_AND_REG, 8'h20);
  endtask
  // The latch holds a different value from the pins, so a latch read shows up.
  task automatic t_port;
    port_pins <= 8'h3C;
    wr(ADDR_PORT, 8'hA5);
    op(OPC_AND_IMM, 8'h00);
    op(OPC_ADD_REG, {1'b0, ADDR_PORT});
    op(OPC_ADD_IMM, 8'hFF);
    op(OPC_AND_REG, {1'b0, ADDR_PORT});
  endtask
  task automatic t_timer;
    prescaler_to_timer <= 1'b1;
    wr(ADDR_TIMER, 8'h40);
    op(OPC_ADD_REG, {1'b0, ADDR_TIMER});
    prescaler_to_timer <= 1'b0;
    op(OPC_ADD_REG, {1'b1, ADDR_TIMER});
  endtask
  task automatic t_bad;
    op(6'h08, 8'h20);
    op(6'h3A, 8'h01);
    op(OPC_AND_IMM, 8'hFF);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    t_imm;
    t_reg;
    t_port;
    t_timer;
    t_bad;
    // The last word commits just before the verdict, so it is judged here.
    @(negedge clock);
    judge;
    report_and_stop;
  end
endmodule
